// File: verilog/mdu_device.sv
// Purpose: muldiv_unit, divide, multiply, shift and normalize coprocessor
// Assumes: Register port strobes synchronous to ref_clk
// Notes: Results computed in one step, finish timed by a cycle counter
`timescale 1ns/1ps
`default_nettype none
`include "mdu_params.svh"
// Overview of operation
// - Write order selects the operation, control count splits shift from normalize
// - Software always writes byte 0 first
// - Fixed write sequences per operation type
// - Last sequence write starts the calculation
// - Runs alongside CPU, finish flag set
// - Finish flag cleared when calculation starts
// - Division and multiply take fixed cycles
// - Shift takes 3 to 18 cycles
// - Normalize takes 4 to 19 cycles
// - Results placed in fixed operand bytes
// - Final result read ends the calculation
// - Shift 32-bit value, byte 3 most significant
// - Direction bit 5, count low five bits
// - Software programs nonzero shift count
// - Zeros shifted in at vacated end
// - Normalize shifts left until top bit set
// - Normalize stores shift count performed
// - Direction 0 left; count 0 normalizes
// - Signedness bit 0 signed, 1 unsigned
// - Error on restart, overflow flag on overflow
// - Finish flag bit 4, resets finished
module mdu_device (
	input wire logic ref_clk,
	input wire logic srst,
	mdu_if.device bus,
	output logic calc_busy
);
	logic [7:0] operand_byte [6];
	logic calc_finish_flag;
	logic signedness_select;
	logic op_error_flag;
	logic op_overflow_flag;
	logic shift_direction;
	logic [4:0] shift_count;
	mdu_pkg::mdu_load_t load;
	mdu_pkg::mdu_load_t next_load;
	mdu_pkg::mdu_op_t op;
	mdu_pkg::mdu_op_t next_op;
	logic start;
	logic [4:0] cyc_left;
	logic [4:0] next_dur;
	logic result_open;
	logic load_wr;
	logic finish;
	logic [31:0] val32;
	logic [15:0] a16;
	logic [15:0] dvs;
	logic [31:0] dvd_ext;
	logic [31:0] dvs_ext;
	logic [31:0] quot;
	logic [31:0] rem;
	logic [31:0] prod;
	logic [31:0] shifted;
	logic [4:0] lead_zeros;
	logic div_ovf;
	logic [2:0] last_read;
	localparam logic [7:0] mode_reset = `MDU_MODE_RESET;
	localparam logic [7:0] ctrl_reset = `MDU_CTRL_RESET;
	// Leading zero count, capped at 31 for an all-zero value
	function automatic logic [4:0] mdu_lzc(input logic [31:0] v);
		logic [4:0] n;
		logic hit;
		n = 5'd31;
		hit = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (v[i] && !hit) begin
				n = 5'(31 - i);
				hit = 1'b1;
			end
		end
		return n;
	endfunction
	assign val32 = {operand_byte[3], operand_byte[2], operand_byte[1], operand_byte[0]};
	assign a16 = {operand_byte[1], operand_byte[0]};
	assign dvs = {operand_byte[5], operand_byte[4]};
	assign load_wr = bus.sfr_wr && (bus.sfr_idx != `MDU_IDX_MODE);
	assign finish = calc_busy && (cyc_left == 5'd0);
	assign lead_zeros = mdu_lzc(val32);
	// Sequence tracker: the write order picks the operation
	always_comb begin
		next_load = load;
		next_op = op;
		start = 1'b0;
		if (load_wr) begin
			next_load = mdu_pkg::LD_IDLE;
			if (bus.sfr_idx == `MDU_IDX_B0) begin
				next_load = mdu_pkg::LD_B0;
			end else begin
				unique case (load)
					mdu_pkg::LD_B0: begin
						if (bus.sfr_idx == `MDU_IDX_B1) next_load = mdu_pkg::LD_B01;
						if (bus.sfr_idx == `MDU_IDX_B4) next_load = mdu_pkg::LD_B04;
					end
					mdu_pkg::LD_B01: begin
						if (bus.sfr_idx == `MDU_IDX_B2) next_load = mdu_pkg::LD_B012;
						if (bus.sfr_idx == `MDU_IDX_B4) next_load = mdu_pkg::LD_B014;
					end
					mdu_pkg::LD_B012: if (bus.sfr_idx == `MDU_IDX_B3) next_load = mdu_pkg::LD_B0123;
					mdu_pkg::LD_B0123: begin
						if (bus.sfr_idx == `MDU_IDX_B4) next_load = mdu_pkg::LD_B01234;
						if (bus.sfr_idx == `MDU_IDX_CTRL) begin
							start = 1'b1;
							next_op = (bus.sfr_wdata[4:0] == 5'd0) ? mdu_pkg::OP_NORM : mdu_pkg::OP_SHIFT;
						end
					end
					mdu_pkg::LD_B01234: begin
						if (bus.sfr_idx == `MDU_IDX_B5) begin
							start = 1'b1;
							next_op = mdu_pkg::OP_DIV32;
						end
					end
					mdu_pkg::LD_B014: begin
						if (bus.sfr_idx == `MDU_IDX_B5) begin
							start = 1'b1;
							next_op = mdu_pkg::OP_DIV16;
						end
					end
					mdu_pkg::LD_B04: if (bus.sfr_idx == `MDU_IDX_B1) next_load = mdu_pkg::LD_B041;
					mdu_pkg::LD_B041: begin
						if (bus.sfr_idx == `MDU_IDX_B5) begin
							start = 1'b1;
							next_op = mdu_pkg::OP_MUL;
						end
					end
					mdu_pkg::LD_IDLE: next_load = mdu_pkg::LD_IDLE;
				endcase
			end
		end
	end
	// Calculation length for the operation being started
	always_comb begin
		next_dur = `MDU_CYC_DIV32;
		unique case (next_op)
			mdu_pkg::OP_DIV32: next_dur = `MDU_CYC_DIV32;
			mdu_pkg::OP_DIV16: next_dur = `MDU_CYC_DIV16;
			mdu_pkg::OP_MUL: next_dur = `MDU_CYC_MUL;
			mdu_pkg::OP_SHIFT: next_dur = `MDU_CYC_SHIFT_BASE + 5'((6'(bus.sfr_wdata[4:0]) + 6'd1) >> 1);
			mdu_pkg::OP_NORM: next_dur = `MDU_CYC_NORM_BASE + 5'(lead_zeros == 5'd0)
				+ 5'((6'(lead_zeros) + 6'd1) >> 1);
		endcase
	end
	// Divider, multiplier and shifter on the held operands
	always_comb begin
		dvd_ext = (op == mdu_pkg::OP_DIV16) ?
			(signedness_select ? {16'h0000, a16} : {{16{a16[15]}}, a16}) : val32;
		dvs_ext = signedness_select ? {16'h0000, dvs} : {{16{dvs[15]}}, dvs};
		quot = 32'hFFFFFFFF;
		rem = dvd_ext;
		div_ovf = 1'b1;
		if (dvs != 16'h0000) begin
			div_ovf = 1'b0;
			if (signedness_select) begin
				quot = dvd_ext / dvs_ext;
				rem = dvd_ext % dvs_ext;
			end else begin
				quot = 32'($signed(dvd_ext) / $signed(dvs_ext));
				rem = 32'($signed(dvd_ext) % $signed(dvs_ext));
				if (dvs == 16'hFFFF) begin
					div_ovf = (op == mdu_pkg::OP_DIV16) ? (a16 == 16'h8000) : (val32 == 32'h80000000);
				end
			end
		end
		prod = signedness_select ? 32'({16'h0000, a16} * {16'h0000, dvs}) :
			32'($signed({{16{a16[15]}}, a16}) * $signed({{16{dvs[15]}}, dvs}));
		if (op == mdu_pkg::OP_NORM) shifted = val32 << lead_zeros;
		else if (shift_direction) shifted = val32 >> shift_count;
		else shifted = val32 << shift_count;
	end
	// Sequence state and selected operation
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			load <= mdu_pkg::LD_IDLE;
			op <= mdu_pkg::OP_DIV32;
		end else begin
			load <= next_load;
			if (start) op <= next_op;
		end
	end
	// Busy timing and finish flag
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			calc_busy <= 1'b0;
			cyc_left <= 5'd0;
			calc_finish_flag <= mode_reset[`MDU_MODE_FINISH_BIT];
		end else if (start) begin
			calc_busy <= 1'b1;
			cyc_left <= next_dur - 5'd1;
			calc_finish_flag <= 1'b0;
		end else if (load_wr && calc_busy) begin
			calc_busy <= 1'b0; // Interrupted by new loading
		end else if (finish) begin
			calc_busy <= 1'b0;
			calc_finish_flag <= 1'b1;
		end else if (calc_busy) begin
			cyc_left <= cyc_left - 5'd1;
		end
	end
	// Operand bytes: loads from the port, results on finish
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < 6; i++) operand_byte[i] <= `MDU_BYTE_RESET;
		end else if (bus.sfr_wr && bus.sfr_idx >= `MDU_IDX_B0) begin
			operand_byte[3'(bus.sfr_idx - `MDU_IDX_B0)] <= bus.sfr_wdata;
		end else if (finish) begin
			unique case (op)
				mdu_pkg::OP_DIV32: begin
					{operand_byte[3], operand_byte[2], operand_byte[1], operand_byte[0]} <= quot;
					{operand_byte[5], operand_byte[4]} <= rem[15:0];
				end
				mdu_pkg::OP_DIV16: begin
					{operand_byte[1], operand_byte[0]} <= quot[15:0];
					{operand_byte[5], operand_byte[4]} <= rem[15:0];
				end
				mdu_pkg::OP_MUL: {operand_byte[3], operand_byte[2], operand_byte[1], operand_byte[0]} <= prod;
				mdu_pkg::OP_SHIFT, mdu_pkg::OP_NORM:
					{operand_byte[3], operand_byte[2], operand_byte[1], operand_byte[0]} <= shifted;
			endcase
		end
	end
	// Mode and control fields
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			signedness_select <= mode_reset[`MDU_MODE_SIGNED_BIT];
			shift_direction <= ctrl_reset[`MDU_CTRL_DIR_BIT];
			shift_count <= ctrl_reset[4:0];
		end else if (bus.sfr_wr && bus.sfr_idx == `MDU_IDX_MODE) begin
			signedness_select <= bus.sfr_wdata[`MDU_MODE_SIGNED_BIT];
		end else if (bus.sfr_wr && bus.sfr_idx == `MDU_IDX_CTRL) begin
			shift_direction <= bus.sfr_wdata[`MDU_CTRL_DIR_BIT];
			shift_count <= bus.sfr_wdata[4:0];
		end else if (finish && op == mdu_pkg::OP_NORM) begin
			shift_count <= lead_zeros;
		end
	end
	// Error and overflow flags, cleared at a clean start
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			op_error_flag <= 1'b0;
			op_overflow_flag <= 1'b0;
		end else begin
			if (load_wr && calc_busy) op_error_flag <= 1'b1;
			else if (start) op_error_flag <= 1'b0;
			if (start) op_overflow_flag <= 1'b0;
			else if (finish && (op == mdu_pkg::OP_DIV32 || op == mdu_pkg::OP_DIV16))
				op_overflow_flag <= div_ovf;
		end
	end
	// Result window closes on the last read of the sequence
	assign last_read = (op == mdu_pkg::OP_DIV32 || op == mdu_pkg::OP_DIV16) ? `MDU_IDX_B5 : `MDU_IDX_B3;
	always_ff @(posedge ref_clk) begin
		if (srst) result_open <= 1'b0;
		else if (finish) result_open <= 1'b1;
		else if (start || (bus.sfr_rd && bus.sfr_idx == last_read)) result_open <= 1'b0;
	end
	// Registered read data
	always_ff @(posedge ref_clk) begin
		if (srst) bus.sfr_rdata <= 8'h00;
		else if (bus.sfr_rd) begin
			unique case (bus.sfr_idx)
				`MDU_IDX_MODE: bus.sfr_rdata <= {3'h0, calc_finish_flag, 2'h0, signedness_select, 1'b0};
				`MDU_IDX_CTRL: bus.sfr_rdata <= {op_error_flag, op_overflow_flag, shift_direction, shift_count};
				default: bus.sfr_rdata <= operand_byte[3'(bus.sfr_idx - `MDU_IDX_B0)];
			endcase
		end
	end
endmodule
`default_nettype wire

// File: verilog/mdu_params.svh
// Purpose: Offsets, field positions, reset values and cycle counts of the muldiv_unit
// Assumes: Included by the package user files by bare name
// Notes: Definitions only
`ifndef MDU_PARAMS_SVH
`define MDU_PARAMS_SVH

// Register index on the byte-wide register port
`define MDU_IDX_MODE 3'h0
`define MDU_IDX_CTRL 3'h1
`define MDU_IDX_B0 3'h2
`define MDU_IDX_B1 3'h3
`define MDU_IDX_B2 3'h4
`define MDU_IDX_B3 3'h5
`define MDU_IDX_B4 3'h6
`define MDU_IDX_B5 3'h7

// Field positions
`define MDU_MODE_FINISH_BIT 4
`define MDU_MODE_SIGNED_BIT 1
`define MDU_CTRL_ERR_BIT 7
`define MDU_CTRL_OVF_BIT 6
`define MDU_CTRL_DIR_BIT 5

// Reset values
`define MDU_MODE_RESET 8'h10
`define MDU_CTRL_RESET 8'h00
`define MDU_BYTE_RESET 8'h00

// Calculation lengths in clock cycles
`define MDU_CYC_DIV32 5'd17
`define MDU_CYC_DIV16 5'd9
`define MDU_CYC_MUL 5'd11
`define MDU_CYC_SHIFT_BASE 5'd2
`define MDU_CYC_NORM_BASE 5'd3
`define MDU_CYC_NORM_MIN 5'd4
`define MDU_CYC_NORM_MAX 5'd19

// APB map of the controller
`define MDU_APB_CMD 12'h000
`define MDU_APB_STATUS 12'h004
`define MDU_CMD_IDX_LSB 8
`define MDU_CMD_READ_BIT 16

`endif

// File: verilog/mdu_pkg.sv
// Purpose: Types shared by both ends of the muldiv_unit link
// Assumes: Nothing
// Notes: Numeric constants live in mdu_params.svh
package mdu_pkg;
	// Progress through a loading sequence
	typedef enum logic [3:0] {
		LD_IDLE, LD_B0, LD_B01, LD_B012, LD_B0123, LD_B01234, LD_B014, LD_B04, LD_B041
	} mdu_load_t;

	// Selected arithmetic operation
	typedef enum logic [2:0] {
		OP_DIV32, OP_DIV16, OP_MUL, OP_SHIFT, OP_NORM
	} mdu_op_t;

	// Controller access sequencing
	typedef enum logic [1:0] {
		H_IDLE, H_RD1, H_RD2
	} mdu_host_state_t;
endpackage

// File: verilog/mdu_if.sv
// Purpose: Byte-wide register port between CPU-side controller and muldiv_unit
// Assumes: One clock; strobes are one-cycle pulses
// Notes: Read data follows a read strobe by one cycle
`timescale 1ns/1ps
`default_nettype none
interface mdu_if;
	logic sfr_wr;
	logic sfr_rd;
	logic [2:0] sfr_idx;
	logic [7:0] sfr_wdata;
	logic [7:0] sfr_rdata;

	modport device (input sfr_wr, input sfr_rd, input sfr_idx, input sfr_wdata, output sfr_rdata);
	modport host (output sfr_wr, output sfr_rd, output sfr_idx, output sfr_wdata, input sfr_rdata);
endinterface
`default_nettype wire

// File: verilog/mdu_host.sv
// Purpose: CPU-side controller driving the muldiv_unit register port from APB
// Assumes: APB master in the ref_clk domain
// Notes: One register access per command write
`timescale 1ns/1ps
`default_nettype none
`include "mdu_params.svh"

module mdu_host (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	mdu_if.host bus
);
	mdu_pkg::mdu_host_state_t state;
	logic cmd_busy;
	logic [7:0] rd_byte;
	logic cmd_take;
	logic mapped;

	assign mapped = (paddr == `MDU_APB_CMD) || (paddr == `MDU_APB_STATUS);
	assign cmd_take = psel && penable && pready && pwrite && (paddr == `MDU_APB_CMD) && !cmd_busy;

	// APB answer one cycle into the access phase
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !mapped;
			prdata <= (paddr == `MDU_APB_STATUS) ? {16'h0000, rd_byte, 7'h00, cmd_busy} : 32'h00000000;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Register port sequencing; software keeps the write order
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= mdu_pkg::H_IDLE;
			cmd_busy <= 1'b0;
			rd_byte <= 8'h00;
			bus.sfr_wr <= 1'b0;
			bus.sfr_rd <= 1'b0;
			bus.sfr_idx <= 3'h0;
			bus.sfr_wdata <= 8'h00;
		end else begin
			bus.sfr_wr <= 1'b0;
			bus.sfr_rd <= 1'b0;
			unique case (state)
				mdu_pkg::H_IDLE: begin
					cmd_busy <= 1'b0;
					if (cmd_take) begin
						bus.sfr_idx <= pwdata[`MDU_CMD_IDX_LSB +: 3];
						bus.sfr_wdata <= pwdata[7:0];
						if (pwdata[`MDU_CMD_READ_BIT]) begin
							bus.sfr_rd <= 1'b1;
							cmd_busy <= 1'b1;
							state <= mdu_pkg::H_RD1;
						end else begin
							bus.sfr_wr <= 1'b1;
						end
					end
				end
				mdu_pkg::H_RD1: state <= mdu_pkg::H_RD2;
				mdu_pkg::H_RD2: begin
					rd_byte <= bus.sfr_rdata;
					cmd_busy <= 1'b0;
					state <= mdu_pkg::H_IDLE;
				end
				default: state <= mdu_pkg::H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: dv/mdu_assertions.sv
// Purpose: Concurrent checks on the muldiv_unit register port and busy output
// Assumes: Single clock ref_clk, srst synchronous active high
// Notes: Write tracking follows the legal loading orders only
`timescale 1ns/1ps
`default_nettype none
`include "mdu_params.svh"
module mdu_assertions (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [2:0] sfr_idx,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	input wire logic calc_busy
);
	logic [2:0] h1, h2;
	logic [4:0] exp_len, run_len;
	logic aborted, start, rd_mode;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// Last write of a loading order while idle
	assign start = sfr_wr && !calc_busy && ((sfr_idx == `MDU_IDX_B5 && (h1 == `MDU_IDX_B1 || h1 == `MDU_IDX_B4))
		|| (sfr_idx == `MDU_IDX_CTRL && h1 == `MDU_IDX_B3));
	assign rd_mode = sfr_rd && sfr_idx == `MDU_IDX_MODE;
	// History of operand and control writes
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			h1 <= 3'h0;
			h2 <= 3'h0;
		end else if (sfr_wr && sfr_idx != `MDU_IDX_MODE) begin
			h1 <= sfr_idx;
			h2 <= h1;
		end
	end
	// Expected busy length, zero for normalize
	always_ff @(posedge ref_clk) begin
		if (srst)
			exp_len <= 5'h00;
		else if (start && sfr_idx == `MDU_IDX_CTRL)
			exp_len <= sfr_wdata[4:0] == 5'h00 ? 5'h00 : `MDU_CYC_SHIFT_BASE + {1'b0, sfr_wdata[4:1]} + {4'h0, sfr_wdata[0]};
		else if (start)
			exp_len <= h1 == `MDU_IDX_B1 ? `MDU_CYC_MUL : (h2 == `MDU_IDX_B3 ? `MDU_CYC_DIV32 : `MDU_CYC_DIV16);
	end
	// Busy cycle count and abort marker
	always_ff @(posedge ref_clk) begin
		if (srst || start) begin
			run_len <= 5'h00;
			aborted <= 1'b0;
		end else begin
			run_len <= run_len + {4'h0, calc_busy};
			if (sfr_wr && calc_busy && sfr_idx != `MDU_IDX_MODE)
				aborted <= 1'b1;
		end
	end
	property p_start;
		start |=> calc_busy;
	endproperty
	a_start: assert property (p_start) else $error("busy missing after last write");
	property p_nostart;
		!start && !calc_busy |=> !calc_busy;
	endproperty
	a_nostart: assert property (p_nostart) else $error("busy without loading order");
	property p_len;
		$fell(calc_busy) && !aborted && exp_len != 5'h00 |-> run_len == exp_len;
	endproperty
	a_len: assert property (p_len) else $error("wrong calculation length");
	property p_norm_len;
		$fell(calc_busy) && !aborted && exp_len == 5'h00 |-> run_len >= `MDU_CYC_NORM_MIN && run_len <= `MDU_CYC_NORM_MAX;
	endproperty
	a_norm_len: assert property (p_norm_len) else $error("normalize length out of range");
	property p_busy_flag;
		rd_mode && calc_busy |=> !sfr_rdata[4];
	endproperty
	a_busy_flag: assert property (p_busy_flag) else $error("finish flag set while busy");
	property p_done_flag;
		rd_mode && !calc_busy && !aborted |=> sfr_rdata[4];
	endproperty
	a_done_flag: assert property (p_done_flag) else $error("finish flag clear when idle");
	property p_abort;
		sfr_wr && calc_busy && sfr_idx != `MDU_IDX_MODE |=> !calc_busy;
	endproperty
	a_abort: assert property (p_abort) else $error("write while busy did not abort");
	property p_err;
		sfr_rd && sfr_idx == `MDU_IDX_CTRL && aborted |=> sfr_rdata[7];
	endproperty
	a_err: assert property (p_err) else $error("error flag not set");
	property p_hold;
		!sfr_rd |=> $stable(sfr_rdata);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved without read");
	property p_pulse;
		sfr_wr || sfr_rd |=> !sfr_wr && !sfr_rd;
	endproperty
	a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
endmodule
`default_nettype wire

// File: dv/multiply_divide_coprocessor_tb.sv
// Purpose: Self-checking bench of the muldiv_unit and its APB controller
// Assumes: 20 MHz ref_clk, one APB access at a time
// Notes: Expected results are worked out here from the operands
`timescale 1ns/1ps
`default_nettype none
`include "mdu_params.svh"
module multiply_divide_coprocessor_tb;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rv, acc, x;
	logic pready, pslverr, e, calc_busy;
	logic [7:0] b;
	logic [15:0] h;
	logic [5:0] sh_tab [4] = '{6'h01, 6'h3F, 6'h1F, 6'h24};
	int bad_count = 0;
	int comparisons = 0;
	int cyc = 0;
	mdu_if bus ();
	mdu_host u_mdu_host (.ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));
	mdu_device u_mdu_device (.ref_clk(ref_clk), .srst(srst), .bus(bus), .calc_busy(calc_busy));
	mdu_assertions u_mdu_assertions (.ref_clk(ref_clk), .srst(srst), .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd),
		.sfr_idx(bus.sfr_idx), .sfr_wdata(bus.sfr_wdata), .sfr_rdata(bus.sfr_rdata), .calc_busy(calc_busy));
	always #25 ref_clk = ~ref_clk;
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer held until pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rv = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic put(input logic [2:0] i, input logic [7:0] d);
		apb(1'b1, `MDU_APB_CMD, {16'h0000, 5'h00, i, d});
	endtask
	// Register read through the controller, polled until done
	task automatic get(input logic [2:0] i);
		apb(1'b1, `MDU_APB_CMD, {15'h0000, 1'b1, 5'h00, i, 8'h00});
		do begin
			apb(1'b0, `MDU_APB_STATUS, 32'h0);
		end while (rv[0] !== 1'b0);
		b = rv[15:8];
	endtask
	task automatic ld4(input logic [31:0] v);
		for (int k = 0; k < 4; k++)
			put(`MDU_IDX_B0 + 3'(k), v[8*k +: 8]);
	endtask
	task automatic rd(input logic [2:0] i, input int n);
		acc = 32'h0;
		for (int k = 0; k < n; k++) begin
			get(i + 3'(k));
			acc[8*k +: 8] = b;
		end
	endtask
	task automatic finish(input logic chk);
		int n = 0;
		get(`MDU_IDX_MODE);
		if (chk)
			check({31'h0, b[4]}, 32'h0);
		while (b[4] !== 1'b1 && n < 10) begin
			get(`MDU_IDX_MODE);
			n++;
		end
		check({31'h0, b[4]}, 32'h1);
	endtask
	task automatic div(input logic u, input logic w, input logic [31:0] a, input logic [15:0] d);
		put(`MDU_IDX_MODE, {6'h00, u, 1'b0});
		put(`MDU_IDX_B0, a[7:0]);
		put(`MDU_IDX_B1, a[15:8]);
		if (w) begin
			put(`MDU_IDX_B2, a[23:16]);
			put(`MDU_IDX_B3, a[31:24]);
		end
		put(`MDU_IDX_B4, d[7:0]);
		put(`MDU_IDX_B5, d[15:8]);
	endtask
	// Main sequence
	initial begin
		int n;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		get(`MDU_IDX_MODE);
		check({24'h0, b}, {24'h0, `MDU_MODE_RESET});
		for (int k = 1; k < 8; k++) begin
			get(3'(k));
			check({24'h0, b}, 32'h0);
		end
		apb(1'b0, 12'h008, 32'h0);
		check({rv[30:0], e}, 32'h1);
		div(1'b1, 1'b1, 32'h89ABCDEF, 16'h1234);
		finish(1'b1);
		rd(`MDU_IDX_B0, 4);
		check(acc, 32'h89ABCDEF / 32'h1234);
		rd(`MDU_IDX_B4, 2);
		check(acc, 32'h89ABCDEF % 32'h1234);
		div(1'b0, 1'b0, 32'h8000, 16'h0007);
		finish(1'b0);
		rd(`MDU_IDX_B0, 2);
		h = $signed(16'h8000) / $signed(16'h0007);
		check(acc, {16'h0, h});
		rd(`MDU_IDX_B4, 2);
		h = $signed(16'h8000) % $signed(16'h0007);
		check(acc, {16'h0, h});
		div(1'b1, 1'b0, 32'h00AB, 16'h0000);
		finish(1'b0);
		get(`MDU_IDX_CTRL);
		check({31'h0, b[6]}, 32'h1);
		rd(`MDU_IDX_B4, 2);
		check(acc, 32'h00AB);
		div(1'b1, 1'b1, 32'h0000FFFF, 16'h0003);
		put(`MDU_IDX_B0, 8'h00);
		get(`MDU_IDX_CTRL);
		check({31'h0, b[7]}, 32'h1);
		get(`MDU_IDX_MODE);
		check({31'h0, b[4]}, 32'h0);
		for (int s = 0; s < 2; s++) begin
			put(`MDU_IDX_MODE, {6'h00, s[0], 1'b0});
			put(`MDU_IDX_B0, 8'hFE);
			put(`MDU_IDX_B4, 8'h03);
			put(`MDU_IDX_B1, 8'hFF);
			put(`MDU_IDX_B5, 8'h00);
			finish(1'b1);
			get(`MDU_IDX_CTRL);
			check({31'h0, b[7]}, 32'h0);
			rd(`MDU_IDX_B0, 4);
			check(acc, (s[0] ? 32'h0000FFFE : 32'hFFFFFFFE) * 32'h00000003);
		end
		for (int k = 0; k < 4; k++) begin
			ld4(32'hC0000003);
			put(`MDU_IDX_CTRL, {2'h0, sh_tab[k]});
			finish(1'b0);
			rd(`MDU_IDX_B0, 4);
			x = sh_tab[k][5] ? 32'hC0000003 >> sh_tab[k][4:0] : 32'hC0000003 << sh_tab[k][4:0];
			check(acc, x);
		end
		for (int k = 0; k < 2; k++) begin
			x = k[0] ? 32'h80000000 : 32'h00012345;
			ld4(x);
			put(`MDU_IDX_CTRL, 8'h00);
			finish(1'b0);
			for (n = 0; n < 31 && !x[31]; n++)
				x = x << 1;
			get(`MDU_IDX_CTRL);
			check({27'h0, b[4:0]}, {27'h0, n[4:0]});
			rd(`MDU_IDX_B0, 4);
			check(acc, x);
		end
		final_report();
	end
endmodule
`default_nettype wire
